// [verilog/unified_writeback_cache.sv]
// Purpose: 2 KB four-way unified write-back cache with SRAM/flush modes.
// Assumes: Core issues one request at a time and waits for done; memory
//          bus controller answers each request with a one-cycle ack.
// Notes:   Hits answer one cycle after the request, which is the core's
//          zero-wait slot; misses and uncached accesses take longer.
`timescale 1ns/1ps

// Summary of operation
// - 512 words as four ways by 128 sets
// - Per-line status and 23-bit tag, separate array
// - Hits served with zero wait states
// - Write hit updates word, sets modified only
// - Modified victim written back before reuse
// - Victim chosen by LRU recency bits
// - Write-backs skip the privilege check
// - Invalid lines ignore tag and miss
// - Modified flag marks word differing from memory
// - Control register resets zero, upper bits reserved
// - Bit 0 enables cache mode
// - Bit 1 enables SRAM mode
// - Bit 2 enables flush mode
// - Bit 3 invalidates every line
// - SRAM window maps onto the data array
// - SRAM privilege from covering segment descriptor
// - Address bits pick way and set
// - Flush access writes back modified lines of set
module unified_writeback_cache
(
   input wire logic i_clk_sys,                   // 200 MHz system clock
   input wire logic i_arst_n,                    // Async reset, active low
   // Register port
   input wire logic [7:0] i_reg_addr,            // Register byte offset
   input wire logic [7:0] i_reg_wdata,           // Register write data
   input wire logic i_reg_wr,                    // Write strobe
   input wire logic i_reg_rd,                    // Read strobe
   output logic [7:0] o_reg_rdata,               // Read data, next cycle
   // Core port
   input wire logic i_cpu_req,                   // Request pulse
   input wire logic i_cpu_we,                    // Write request
   input wire logic [31:0] i_cpu_addr,           // Byte address
   input wire logic [31:0] i_cpu_wdata,          // Write data
   input wire logic i_cpu_user,                  // User-mode access
   input wire logic i_seg_user_ok,               // Descriptor allows user
   output logic o_cpu_done,                      // Answer pulse
   output logic o_cpu_abort,                     // Refused, with done
   output logic [31:0] o_cpu_rdata,              // Read data at done
   // External memory port
   output wbcache_pkg::mem_req_t o_mem,          // Memory request
   input wire logic i_mem_ack,                   // Request completed
   input wire logic [31:0] i_mem_rdata,          // Read data at ack
   output logic o_busy                           // Controller not idle
);
   import wbcache_pkg::*;

   // Reset synchroniser: async assert, two-flop release
   logic [1:0] rst_pipe_q;
   logic rst_n;

   // Data and tag arrays; status bits kept per set
   logic [31:0] data_mem [0:WAYS-1][0:SETS-1];
   logic [TAG_W-1:0] tag_mem [0:WAYS-1][0:SETS-1];
   logic [WAYS-1:0] valid_q [0:SETS-1];          // Valid flag per line
   logic [WAYS-1:0] mod_q [0:SETS-1];            // Modified flag per line
   logic [WAYS-1:0] lru_q [0:SETS-1];            // Recency bit per line

   state_t st_q;
   state_t st_d;

   // Array update commands from the controller
   logic data_we;
   logic [1:0] wr_way;
   logic [6:0] wr_set;
   logic [31:0] wr_data;
   logic tag_we;
   logic tag_mod;
   logic mod_set;
   logic mod_clr;
   logic lru_touch;

   // Decode of the incoming request
   logic [6:0] req_set;
   logic [1:0] req_way;
   logic [TAG_W-1:0] req_tag;
   logic in_win;
   logic [WAYS-1:0] hit_vec;
   logic hit;
   logic [1:0] hit_way;
   logic [6:0] cur_set;

   // Marks one line as most recent; clears the rest once all are set
   function automatic logic [WAYS-1:0] lru_mark(input logic [WAYS-1:0] cur,
                                                input logic [1:0] w);
      logic [WAYS-1:0] nxt;
      nxt = cur | (WAYS'(1) << w);
      if (&nxt)
      begin
         nxt = WAYS'(1) << w;
      end
      return nxt;
   endfunction : lru_mark

   // Victim is the first invalid line, else the first not-recent line
   function automatic logic [1:0] pick_victim(input logic [WAYS-1:0] v,
                                              input logic [WAYS-1:0] r);
      logic [1:0] sel;
      logic found;
      sel = 2'h0;
      found = 1'b0;
      for (int i = 0; i < WAYS; i++)
      begin
         if (!found && !v[i])
         begin
            sel = 2'(i);
            found = 1'b1;
         end
      end
      for (int i = 0; i < WAYS; i++)
      begin
         if (!found && !r[i])
         begin
            sel = 2'(i);
            found = 1'b1;
         end
      end
      return sel;
   endfunction : pick_victim

   // Reset release; the pipe takes only constants under reset
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rst_pipe_q <= 2'b00;
      end
      else
      begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_q[1];

   // Address fields of the request on the port
   assign req_set = i_cpu_addr[SET_MSB:SET_LSB];
   assign req_way = i_cpu_addr[WAY_MSB:WAY_LSB];
   assign req_tag = i_cpu_addr[31:TAG_LSB];
   assign cur_set = st_q.cur.addr[SET_MSB:SET_LSB];
   // Whole 2 KB window, only in SRAM or flush mode
   assign in_win = (i_cpu_addr[31:WIN_LSB] == WIN_BASE[31:WIN_LSB])
                   && (st_q.ctrl[CTRL_SRAM] || st_q.ctrl[CTRL_FLUSH]);

   // Tag compare; an invalid line never hits whatever its tag holds
   always_comb
   begin
      hit_way = 2'h0;
      for (int i = 0; i < WAYS; i++)
      begin
         hit_vec[i] = valid_q[req_set][i]
                      && (tag_mem[i][req_set] == req_tag);
      end
      for (int i = 0; i < WAYS; i++)
      begin
         if (hit_vec[i])
         begin
            hit_way = 2'(i);
         end
      end
   end
   assign hit = |hit_vec;

   // Controller: next state and array commands
   always_comb
   begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.abort = 1'b0;
      data_we = 1'b0;
      wr_way = req_way;
      wr_set = req_set;
      wr_data = i_cpu_wdata;
      tag_we = 1'b0;
      tag_mod = 1'b0;
      mod_set = 1'b0;
      mod_clr = 1'b0;
      lru_touch = 1'b0;

      // Register port; reserved bits read zero
      if (i_reg_wr && i_reg_addr == OFS_CTRL)
      begin
         st_d.ctrl = i_reg_wdata[3:0];
      end
      st_d.reg_rdata = 8'h00;
      if (i_reg_rd && i_reg_addr == OFS_CTRL)
      begin
         st_d.reg_rdata = {4'h0, st_q.ctrl};
      end
      else if (i_reg_rd && i_reg_addr == OFS_STAT)
      begin
         st_d.reg_rdata = {7'h00, st_q.busy};
      end

      unique case (st_q.fsm)
         ST_IDLE:
         begin
            if (i_cpu_req)
            begin
               st_d.cur.we = i_cpu_we;
               st_d.cur.addr = i_cpu_addr;
               st_d.cur.wdata = i_cpu_wdata;
               if (in_win && i_cpu_user && !i_seg_user_ok)
               begin
                  // User access refused by the covering descriptor
                  st_d.done = 1'b1;
                  st_d.abort = 1'b1;
               end
               else if (in_win)
               begin
                  // Direct data array access; word only by the master
                  data_we = i_cpu_we;
                  st_d.rdata = data_mem[req_way][req_set];
                  if (st_q.ctrl[CTRL_FLUSH])
                  begin
                     st_d.way = 2'h0;
                     st_d.fsm = ST_FLUSH;
                  end
                  else
                  begin
                     st_d.done = 1'b1;
                  end
               end
               else if (st_q.ctrl[CTRL_EN] && !st_q.ctrl[CTRL_INVAL])
               begin
                  if (hit)
                  begin
                     // Served in the next cycle without memory
                     st_d.done = 1'b1;
                     st_d.rdata = data_mem[hit_way][req_set];
                     wr_way = hit_way;
                     data_we = i_cpu_we;
                     mod_set = i_cpu_we;
                     lru_touch = 1'b1;
                  end
                  else
                  begin
                     st_d.way = pick_victim(valid_q[req_set],
                                            lru_q[req_set]);
                     st_d.fsm = ST_FILL;
                     if (valid_q[req_set][st_d.way]
                         && mod_q[req_set][st_d.way])
                     begin
                        // Dirty victim leaves first, no privilege check
                        st_d.mem.req = 1'b1;
                        st_d.mem.we = 1'b1;
                        st_d.mem.priv_chk = 1'b0;
                        st_d.mem.addr = {tag_mem[st_d.way][req_set],
                                         req_set, 2'b00};
                        st_d.mem.wdata = data_mem[st_d.way][req_set];
                        st_d.fsm = ST_WBACK;
                     end
                     else if (!i_cpu_we)
                     begin
                        st_d.mem.req = 1'b1;
                        st_d.mem.we = 1'b0;
                        st_d.mem.priv_chk = 1'b1;
                        st_d.mem.addr = i_cpu_addr;
                     end
                  end
               end
               else
               begin
                  // Cache off or invalid: straight to memory
                  st_d.mem.req = 1'b1;
                  st_d.mem.we = i_cpu_we;
                  st_d.mem.priv_chk = 1'b1;
                  st_d.mem.addr = i_cpu_addr;
                  st_d.mem.wdata = i_cpu_wdata;
                  st_d.fsm = ST_UNCAC;
               end
            end
         end
         ST_WBACK:
         begin
            if (i_mem_ack)
            begin
               // Victim now clean; fetch the new word unless writing
               mod_clr = 1'b1;
               wr_set = cur_set;
               wr_way = st_q.way;
               st_d.mem.req = !st_q.cur.we;
               st_d.mem.we = 1'b0;
               st_d.mem.priv_chk = 1'b1;
               st_d.mem.addr = st_q.cur.addr;
               st_d.fsm = ST_FILL;
            end
         end
         ST_FILL:
         begin
            // A one-word line needs no fill on a write miss
            if (st_q.cur.we || i_mem_ack)
            begin
               st_d.mem.req = 1'b0;
               wr_set = cur_set;
               wr_way = st_q.way;
               wr_data = st_q.cur.we ? st_q.cur.wdata : i_mem_rdata;
               data_we = 1'b1;
               tag_we = 1'b1;
               tag_mod = st_q.cur.we;
               lru_touch = 1'b1;
               st_d.rdata = i_mem_rdata;
               st_d.done = 1'b1;
               st_d.fsm = ST_IDLE;
            end
         end
         ST_FLUSH:
         begin
            wr_set = cur_set;
            wr_way = st_q.way;
            if (st_q.mem.req)
            begin
               if (i_mem_ack)
               begin
                  st_d.mem.req = 1'b0;
                  mod_clr = 1'b1;
               end
            end
            else if (valid_q[cur_set][st_q.way] && mod_q[cur_set][st_q.way])
            begin
               st_d.mem.req = 1'b1;
               st_d.mem.we = 1'b1;
               st_d.mem.priv_chk = 1'b0;
               st_d.mem.addr = {tag_mem[st_q.way][cur_set], cur_set, 2'b00};
               st_d.mem.wdata = data_mem[st_q.way][cur_set];
            end
            else if (st_q.way == 2'(WAYS - 1))
            begin
               st_d.done = 1'b1;
               st_d.fsm = ST_IDLE;
            end
            else
            begin
               st_d.way = st_q.way + 2'h1;
            end
         end
         ST_UNCAC:
         begin
            if (i_mem_ack)
            begin
               st_d.mem.req = 1'b0;
               st_d.rdata = i_mem_rdata;
               st_d.done = 1'b1;
               st_d.fsm = ST_IDLE;
            end
         end
         default:
         begin
            st_d.fsm = ST_IDLE;
         end
      endcase
      st_d.busy = st_d.fsm != ST_IDLE;
   end

   // Control state register
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RST;
         st_q.fsm <= ST_IDLE;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Data and tag arrays hold no reset; status bits decide their use
   always_ff @(posedge i_clk_sys)
   begin
      if (data_we)
      begin
         data_mem[wr_way][wr_set] <= wr_data;
      end
      if (tag_we)
      begin
         tag_mem[wr_way][wr_set] <= st_q.cur.addr[31:TAG_LSB];
      end
   end

   // Status bits; invalidate mode wipes every line while it is set
   always_ff @(posedge i_clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int s = 0; s < SETS; s++)
         begin
            valid_q[s] <= '0;
            mod_q[s] <= '0;
            lru_q[s] <= '0;
         end
      end
      else if (st_q.ctrl[CTRL_INVAL])
      begin
         for (int s = 0; s < SETS; s++)
         begin
            valid_q[s] <= '0;
            mod_q[s] <= '0;
         end
      end
      else
      begin
         if (tag_we)
         begin
            valid_q[wr_set][wr_way] <= 1'b1;
            mod_q[wr_set][wr_way] <= tag_mod;
         end
         else if (mod_set)
         begin
            mod_q[wr_set][wr_way] <= 1'b1;
         end
         else if (mod_clr)
         begin
            mod_q[wr_set][wr_way] <= 1'b0;
         end
         if (lru_touch)
         begin
            lru_q[wr_set] <= lru_mark(lru_q[wr_set], wr_way);
         end
      end
   end

   // Outputs straight from the state register
   assign o_reg_rdata = st_q.reg_rdata;
   assign o_cpu_done = st_q.done;
   assign o_cpu_abort = st_q.abort;
   assign o_cpu_rdata = st_q.rdata;
   assign o_mem = st_q.mem;
   assign o_busy = st_q.busy;

endmodule : unified_writeback_cache

// [verilog/wbcache_pkg.sv]
// Purpose: Shared constants and carrier types of the write-back cache.
// Assumes: One 200 MHz system clock, word-only core accesses.
// Notes:   Register offsets are byte addresses on the 8-bit register port.
package wbcache_pkg;

   // Geometry
   localparam int WAYS = 4;                      // Lines per set
   localparam int SETS = 128;                    // Sets in the store
   localparam int TAG_W = 23;                    // Address tag width
   localparam int SET_LSB = 2;                   // Set index low bit
   localparam int SET_MSB = 8;                   // Set index high bit
   localparam int WAY_LSB = 9;                   // SRAM-mode way low bit
   localparam int WAY_MSB = 10;                  // SRAM-mode way high bit
   localparam int TAG_LSB = 9;                   // Tag low bit
   localparam int WIN_LSB = 11;                  // Window compare low bit

   // Data array window in SRAM and flush modes
   localparam logic [31:0] WIN_BASE = 32'h6000_0800;
   localparam logic [31:0] WIN_LAST = 32'h6000_0FFF;

   // Register map
   localparam logic [7:0] OFS_CTRL = 8'h00;      // cache_control
   localparam logic [7:0] OFS_STAT = 8'h04;      // busy status
   localparam logic [3:0] CTRL_RST = 4'h0;       // Control reset value
   localparam int CTRL_EN = 0;                   // Cache mode enable
   localparam int CTRL_SRAM = 1;                 // SRAM mode enable
   localparam int CTRL_FLUSH = 2;                // Flush mode enable
   localparam int CTRL_INVAL = 3;                // Invalidate mode

   // Controller states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WBACK = 3'b001,
      ST_FILL  = 3'b010,
      ST_FLUSH = 3'b011,
      ST_UNCAC = 3'b100
   } fsm_t;

   // Request toward the external memory bus controller
   typedef struct packed {
      logic        req;        // Held until acknowledge
      logic        we;         // Write when set
      logic        priv_chk;   // Apply system/user check
      logic [31:0] addr;       // Byte address
      logic [31:0] wdata;      // Write data
   } mem_req_t;

   // Latched core request
   typedef struct packed {
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } core_req_t;

   // All control state of the cache
   typedef struct packed {
      fsm_t        fsm;
      logic [3:0]  ctrl;       // Control bits 3..0
      core_req_t   cur;        // Request in service
      logic [1:0]  way;        // Victim or flush way
      mem_req_t    mem;        // Memory request
      logic        done;       // Core answer pulse
      logic        abort;      // Privilege refusal pulse
      logic [31:0] rdata;      // Core read data
      logic [7:0]  reg_rdata;  // Register read data
      logic busy; // Controller not idle
   } state_t;

endpackage : wbcache_pkg

// [verif/wbcache_props.sv]
// Purpose: Port-level checks of the write-back cache.
// Assumes: Control is written at offset 0 with single strobes.
// Notes:   A mirror of the control bits lets checks follow the mode.
`timescale 1ns/1ps
module wbcache_props
   import wbcache_pkg::*;
(
   input wire logic i_clk_sys, // System clock
   input wire logic i_arst_n, // Async reset, active low
   input wire logic [7:0] i_reg_addr, // Register offset
   input wire logic [7:0] i_reg_wdata, // Register write data
   input wire logic i_reg_wr, // Write strobe
   input wire logic i_reg_rd, // Read strobe
   input wire logic [7:0] o_reg_rdata, // Register read data
   input wire logic i_cpu_req, // Core request
   input wire logic [31:0] i_cpu_addr, // Core address
   input wire logic i_cpu_user, // User-mode access
   input wire logic i_seg_user_ok, // Descriptor allows user
   input wire logic o_cpu_done, // Answer pulse
   input wire logic o_cpu_abort, // Refusal pulse
   input wire wbcache_pkg::mem_req_t o_mem, // Memory request
   input wire logic i_mem_ack, // Memory acknowledge
   input wire logic o_busy // Controller busy
);
   logic [3:0] ctrl_q; // Mirror of control bits
   logic win; // Address inside the data window
   logic take; // Request the cache will accept
   assign win = i_cpu_addr[31:WIN_LSB] == WIN_BASE[31:WIN_LSB];
   assign take = i_cpu_req && !o_busy;
   // Follow software writes; reserved bits are dropped
   always_ff @(posedge i_clk_sys or negedge i_arst_n)
   begin
      if (!i_arst_n)
         ctrl_q <= 4'h0;
      else if (i_reg_wr && i_reg_addr == OFS_CTRL)
         ctrl_q <= i_reg_wdata[3:0];
   end
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);
   // Memory request with privilege check within two cycles
   sequence s_mem_checked;
      ##[1:2] (o_mem.req && o_mem.priv_chk);
   endsequence
   // Answer next cycle with no memory traffic
   sequence s_quick_done;
      ##1 (o_cpu_done && !o_mem.req);
   endsequence
   ctrl_readback_a: assert property (
      i_reg_rd && i_reg_addr == OFS_CTRL |=> o_reg_rdata == {4'h0, ctrl_q})
      else $error("control read data wrong");
   rdata_idle_a: assert property (
      !$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
      else $error("register read data not idle");
   abort_with_done_a: assert property (
      o_cpu_abort |-> o_cpu_done)
      else $error("abort without done");
   user_refused_a: assert property (
      take && win && ctrl_q == 4'h2 && i_cpu_user && !i_seg_user_ok
      |=> o_cpu_done && o_cpu_abort)
      else $error("user access not refused");
   sram_quick_a: assert property (
      take && win && ctrl_q == 4'h2 |-> s_quick_done)
      else $error("window access not served at once");
   wback_nopriv_a: assert property (
      (ctrl_q == 4'h1 || ctrl_q == 4'h4) && o_mem.req && o_mem.we
      |-> !o_mem.priv_chk)
      else $error("write-back carries privilege check");
   inval_miss_a: assert property (
      take && !win && ctrl_q[3] |-> s_mem_checked)
      else $error("access hit while invalidating");
   cache_off_a: assert property (
      take && !win && ctrl_q == 4'h0 |-> s_mem_checked)
      else $error("access cached while disabled");
   mem_hold_a: assert property (
      o_mem.req && !i_mem_ack |=> $stable(o_mem))
      else $error("memory request changed before ack");
   done_pulse_a: assert property (
      o_cpu_done |=> !o_cpu_done)
      else $error("done longer than one cycle");
   answer_bound_a: assert property (
      take |-> ##[1:120] o_cpu_done)
      else $error("core request never answered");
endmodule : wbcache_props

bind unified_writeback_cache wbcache_props i_wbcache_props (
   .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .i_cpu_req(i_cpu_req),
   .i_cpu_addr(i_cpu_addr), .i_cpu_user(i_cpu_user),
   .i_seg_user_ok(i_seg_user_ok), .o_cpu_done(o_cpu_done),
   .o_cpu_abort(o_cpu_abort), .o_mem(o_mem), .i_mem_ack(i_mem_ack),
   .o_busy(o_busy));

// [verif/ext_mem_model.sv]
// Purpose: External memory bus controller model behind the cache.
// Assumes: One request at a time, held until acknowledge.
// Notes:   Idle read data toggles so a stale word never passes.
`timescale 1ns/1ps
module ext_mem_model
   import wbcache_pkg::*;
(
   input wire logic i_clk_sys, // System clock
   input wire wbcache_pkg::mem_req_t i_mem, // Request from cache
   input wire logic [3:0] i_wait, // Cycles before acknowledge
   output logic o_ack, // One-cycle completion
   output logic [31:0] o_rdata // Read data with ack
);
   logic [31:0] store [logic [31:0]]; // Words written so far
   logic [3:0] cnt = 4'h0; // Cycles the request has waited
   int n_wr = 0; // Writes seen
   logic [31:0] last_addr = 32'h0; // Last write address
   logic [31:0] last_data = 32'h0; // Last write data
   logic last_chk = 1'b0; // Privilege flag of last write
   initial o_ack = 1'b0;
   initial o_rdata = 32'h0;
   // Count the wait, then complete once; the ack cycle restarts it
   always @(posedge i_clk_sys)
   begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata; // Released data never holds
      if (!i_mem.req || o_ack)
         cnt <= 4'h0;
      else if (cnt != i_wait)
         cnt <= cnt + 4'h1;
      else
      begin
         o_ack <= 1'b1;
         if (i_mem.we)
         begin
            store[i_mem.addr] = i_mem.wdata;
            n_wr++;
            last_addr = i_mem.addr;
            last_data = i_mem.wdata;
            last_chk = i_mem.priv_chk;
         end
         else if (store.exists(i_mem.addr))
            o_rdata <= store[i_mem.addr];
         else
            o_rdata <= i_mem.addr ^ 32'hA5A5_0000; // Unwritten pattern
      end
   end
endmodule : ext_mem_model

// [verif/unified_writeback_cache_test.sv]
// Purpose: Directed test of modes, write-back and register of the cache.
// Assumes: Memory model returns address xor a pattern for unwritten words.
// Notes:   Latency 1 means zero wait states on the core port.
`timescale 1ns/1ps
module unified_writeback_cache_test;
   import wbcache_pkg::*;
   localparam logic [31:0] PAT = 32'hA5A5_0000; // Unwritten memory
   logic clk, arst_n, wr_stb, rd_stb, cpu_req, cpu_we, cpu_user, seg_ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, r8;
   logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, mem_rdata, rd;
   logic cpu_done, cpu_abort, mem_ack, busy, ab;
   logic [3:0] mem_wait; // Memory speed
   mem_req_t mem; // Request toward memory
   int lat, mismatches = 0, n_compared = 0, cycles = 0;
   unified_writeback_cache i_unified_writeback_cache (.i_clk_sys(clk),
      .i_arst_n(arst_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(wr_stb), .i_reg_rd(rd_stb), .o_reg_rdata(reg_rdata),
      .i_cpu_req(cpu_req), .i_cpu_we(cpu_we), .i_cpu_addr(cpu_addr),
      .i_cpu_wdata(cpu_wdata), .i_cpu_user(cpu_user),
      .i_seg_user_ok(seg_ok), .o_cpu_done(cpu_done),
      .o_cpu_abort(cpu_abort), .o_cpu_rdata(cpu_rdata), .o_mem(mem),
      .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_busy(busy));
   ext_mem_model i_ext_mem_model (.i_clk_sys(clk), .i_mem(mem),
      .i_wait(mem_wait), .o_ack(mem_ack), .o_rdata(mem_rdata));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic close_out;
   begin
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask : close_out
   // Cut a hang short
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
   begin
      n_compared++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   end
   endtask : chk
   task automatic reg_write(input logic [7:0] a, d);
   begin
      @(posedge clk);
      wr_stb <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
   end
   endtask : reg_write
   // Read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
   begin
      @(posedge clk);
      rd_stb <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      d = reg_rdata;
   end
   endtask : reg_read
   // One core access; fast marks a zero-wait answer
   task automatic cpu(input logic we, input logic [31:0] a, wd,
      input logic usr, ok, fast);
   begin
      @(posedge clk);
      cpu_req <= 1'b1;
      cpu_we <= we;
      cpu_addr <= a;
      cpu_wdata <= wd;
      cpu_user <= usr;
      seg_ok <= ok;
      @(posedge clk);
      cpu_req <= 1'b0;
      #1;
      lat = 1;
      while (cpu_done !== 1'b1 && lat < 200)
      begin
         @(posedge clk);
         #1;
         lat++;
      end
      if (lat >= 200)
         mismatches++;
      rd = cpu_rdata;
      ab = cpu_abort;
      chk("fast answer", 32'(lat == 1), 32'(fast));
   end
   endtask : cpu
   task automatic wcount(input int e);
   begin
      chk("mem writes", 32'(i_ext_mem_model.n_wr), 32'(e));
   end
   endtask : wcount
   initial
   begin
      {arst_n, wr_stb, rd_stb, cpu_req, cpu_we, cpu_user, seg_ok} = '0;
      {reg_addr, reg_wdata, cpu_addr, cpu_wdata} = '0;
      mem_wait = 4'h2;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      reg_read(OFS_CTRL, r8);
      chk("ctrl reset", 32'(r8), 32'h0);
      reg_read(OFS_STAT, r8);
      chk("busy", 32'(r8), 32'h0);
      cpu(0, 32'h2000, 0, 0, 1, 0);
      chk("uncached", rd, 32'h2000 ^ PAT);
      cpu(0, 32'h2000, 0, 0, 1, 0);
      reg_write(OFS_CTRL, 8'hF1);
      reg_read(OFS_CTRL, r8);
      chk("ctrl", 32'(r8), 32'h1);
      reg_read(8'h08, r8);
      chk("unmapped", 32'(r8), 32'h0);
      cpu(0, 32'h1000, 0, 0, 1, 0);
      chk("fill", rd, 32'h1000 ^ PAT);
      cpu(0, 32'h1000, 0, 0, 1, 1);
      cpu(1, 32'h1000, 32'h1111_1111, 0, 1, 1);
      wcount(0);
      cpu(0, 32'h1000, 0, 0, 1, 1);
      chk("hit data", rd, 32'h1111_1111);
      mem_wait = 4'h6;
      for (int i = 1; i < 4; i++)
         cpu(0, 32'h1000 + 32'(i) * 32'h200, 0, 0, 1, 0);
      cpu(0, 32'h1800, 0, 0, 1, 0);
      wcount(1);
      chk("wb addr", i_ext_mem_model.last_addr, 32'h1000);
      chk("wb data", i_ext_mem_model.last_data, 32'h1111_1111);
      chk("wb priv", 32'(i_ext_mem_model.last_chk), 32'h0);
      chk("refill", rd, 32'h1800 ^ PAT);
      cpu(0, 32'h1200, 0, 0, 1, 1);
      cpu(1, 32'h1400, 32'h2222_2222, 0, 1, 1);
      mem_wait = 4'h0;
      reg_write(OFS_CTRL, 8'h04);
      cpu(0, 32'h6000_0800, 0, 0, 1, 0);
      chk("flush rd", rd, 32'h1800 ^ PAT);
      wcount(2);
      chk("fl addr", i_ext_mem_model.last_addr, 32'h1400);
      chk("fl data", i_ext_mem_model.last_data, 32'h2222_2222);
      for (int s = 0; s < SETS; s++)
         cpu(0, 32'h6000_0800 + 32'(s * 4), 0, 0, 1, 0);
      wcount(2);
      reg_write(OFS_CTRL, 8'h08);
      cpu(0, 32'h1200, 0, 0, 1, 0);
      chk("inval rd", rd, 32'h1200 ^ PAT);
      reg_write(OFS_CTRL, 8'h01);
      cpu(0, 32'h1200, 0, 0, 1, 0);
      cpu(0, 32'h1200, 0, 0, 1, 1);
      reg_write(OFS_CTRL, 8'h02);
      cpu(0, 32'h6000_0800, 0, 0, 1, 1);
      chk("sram rd", rd, 32'h1200 ^ PAT);
      cpu(1, 32'h6000_0E04, 32'hCAFE_0001, 0, 1, 1);
      cpu(1, 32'h6000_0E04, 32'hDEAD_0002, 1, 0, 1);
      chk("abort", 32'(ab), 32'h1);
      cpu(0, 32'h6000_0E04, 0, 1, 1, 1);
      chk("sram data", rd, 32'hCAFE_0001);
      chk("no abort", 32'(ab), 32'h0);
      wcount(2);
      close_out();
   end
endmodule : unified_writeback_cache_test
